// ### rtl/scr_defs.svh
/*
  Constants for the serial configuration register bank: offsets, field
  positions, reset values, pin indices and timing counts.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

`define SCR_ADDR_W          15
`define SCR_OFS_IFCFG       15'h0000
`define SCR_OFS_TYPE        15'h0003
`define SCR_OFS_ID_LOW      15'h0004
`define SCR_OFS_ID_HIGH     15'h0005
`define SCR_OFS_TEST_CTRL   15'h0520
`define SCR_OFS_CONST_I_LO  15'h0521
`define SCR_OFS_CONST_I_HI  15'h0522
`define SCR_OFS_CONST_Q_LO  15'h0523
`define SCR_OFS_CONST_Q_HI  15'h0524

`define SCR_IFCFG_RST_BIT   0
`define SCR_IFCFG_ORDER_BIT 1
`define SCR_IFCFG_STEP_BIT  2
`define SCR_IFCFG_SDOEN_BIT 3
`define SCR_TEST_EN_BIT     1

`define SCR_IFCFG_RESET     3'h0
`define SCR_TEST_CTRL_RESET 8'h1c
`define SCR_CONST_RESET     8'h00
`define SCR_UNMAPPED_READ   8'h00

`define SCR_PIN_CS          0
`define SCR_PIN_SCLK        1
`define SCR_PIN_SDIO        2
`define SCR_PIN_IDLE        3'h1

`define SCR_INSTR_LAST      4'hf
`define SCR_BYTE_LAST       4'h7

`define SCR_CLK_MHZ         200
`define SCR_SOFT_RESET_NS   80
`define SCR_SOFT_RESET_CYC  ((`SCR_SOFT_RESET_NS * `SCR_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/scr_pin_if.sv
/*
  Carrier of the synchronised serial pin levels and their edge pulses.
  Assumes one clock shared by the pin front end and the core.
*/
interface scr_pin_if;
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;

  modport front (output lvl, output rise, output fall);
  modport core  (input lvl, input rise, input fall);
endinterface : scr_pin_if

// ### rtl/scr_pin_sync.sv
/*
  Three-flop synchronisers with agreement filter for the serial pins.
  Assumes the pins are asynchronous to i_clock and change far slower.
*/
`include "scr_defs.svh"

module scr_pin_sync (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic [2:0] i_pins,
  scr_pin_if.front        pin
);

  localparam logic [2:0] pin_idle = `SCR_PIN_IDLE;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;

      // s1 feeds only s2; a level counts once s2 and s3 agree
      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          s1_q         <= pin_idle[g];
          s2_q         <= pin_idle[g];
          s3_q         <= pin_idle[g];
          pin.lvl[g]   <= pin_idle[g];
          pin.rise[g]  <= 1'b0;
          pin.fall[g]  <= 1'b0;
        end else begin
          s1_q        <= i_pins[g];
          s2_q        <= s1_q;
          s3_q        <= s2_q;
          pin.rise[g] <= (s2_q == s3_q) && s3_q && !pin.lvl[g];
          pin.fall[g] <= (s2_q == s3_q) && !s3_q && pin.lvl[g];
          if (s2_q == s3_q) begin
            pin.lvl[g] <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule : scr_pin_sync

// ### rtl/scr_pkg.sv
/*
  Types of the serial configuration register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scr_pkg;
  typedef enum logic [0:0] {
    ST_INSTR,
    ST_DATA
  } scr_state_type;

  typedef logic [7:0] scr_byte_type;
endpackage : scr_pkg

// ### rtl/scr_top.sv
/*
  Serial-port configuration and identification register bank: 3/4-wire
  serial slave, interface configuration byte, type and id bytes, and the
  constant I/Q test registers.
  Assumes serial clock idles low, data sampled on its rising edge, and a
  serial clock at most one tenth of I_CLOCK.
*/
// Function
// R1: address steps up if bit set, else down
// R2: bit order selects lsb or msb first
// R3: reset bit starts soft reset, self-clears
// R4: fixed read-only product type code
// R5: upper nibble mirrors lower nibble reversed
`include "scr_defs.svh"

module scr_top #(
  parameter logic [7:0] TYPE_CODE = 8'h5a,  // value arbitrary
  parameter logic [7:0] ID_LOW    = 8'h3c,  // value arbitrary
  parameter logic [7:0] ID_HIGH   = 8'ha7   // value arbitrary
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RESET,
  input  wire logic        I_CS_N,
  input  wire logic        I_SCLK,
  input  wire logic        I_SDIO_IN,
  output logic             O_SDIO_OUT,
  output logic             O_SDIO_OE,
  output logic             O_SDO,
  output logic             O_SDO_OE,
  output logic             O_SOFT_RESET_ACTIVE,
  output logic             O_CONST_TEST_ENABLE,
  output logic [15:0]      O_CONST_I_SAMPLE,
  output logic [15:0]      O_CONST_Q_SAMPLE
);

  scr_pin_if pin ();

  scr_pin_sync u_sync (
    .i_clock (I_CLOCK),
    .i_reset (I_RESET),
    .i_pins  ({I_SDIO_IN, I_SCLK, I_CS_N}),
    .pin     (pin)
  );

  scr_pkg::scr_state_type       state_q;
  logic [3:0]                   bit_cnt_q;
  logic [15:0]                  shift_q;
  logic [15:0]                  shift_d;
  logic                         rw_q;
  logic [`SCR_ADDR_W-1:0]       addr_q;
  logic [`SCR_ADDR_W-1:0]       addr_step;
  logic [`SCR_ADDR_W-1:0]       rd_addr;
  scr_pkg::scr_byte_type        wr_byte;
  scr_pkg::scr_byte_type        rd_data;
  scr_pkg::scr_byte_type        tx_q;
  logic                         wr_en;
  logic                         rd_load;
  logic                         instr_done;
  logic                         byte_done;
  logic                         sel;

  logic                         rst_req_q;
  logic [4:0]                   rst_cnt_q;
  logic                         order_q;
  logic                         step_q;
  logic                         sdo_en_q;
  scr_pkg::scr_byte_type        test_ctrl_q;
  scr_pkg::scr_byte_type        ci_lo_q;
  scr_pkg::scr_byte_type        ci_hi_q;
  scr_pkg::scr_byte_type        cq_lo_q;
  scr_pkg::scr_byte_type        cq_hi_q;

  logic                         sdio_out_q;
  logic                         sdio_oe_q;
  logic                         sdo_q;
  logic                         sdo_oe_q;

  assign sel = !pin.lvl[`SCR_PIN_CS];

  // incoming bit lands at the top in lsb-first order, at the bottom otherwise
  always_comb begin
    if (order_q) begin
      shift_d = {pin.lvl[`SCR_PIN_SDIO], shift_q[15:1]};  // [R2]
      wr_byte = shift_d[15:8];                            // [R2]
    end else begin
      shift_d = {shift_q[14:0], pin.lvl[`SCR_PIN_SDIO]};  // [R2]
      wr_byte = shift_d[7:0];                             // [R2]
    end
  end

  // instruction word: bit 15 read flag, bits 14:0 address, either order
  assign instr_done = sel && pin.rise[`SCR_PIN_SCLK] && (state_q == scr_pkg::ST_INSTR)
                      && (bit_cnt_q == `SCR_INSTR_LAST);
  assign byte_done  = sel && pin.rise[`SCR_PIN_SCLK] && (state_q == scr_pkg::ST_DATA)
                      && (bit_cnt_q == `SCR_BYTE_LAST);

  assign addr_step = step_q ? addr_q + 1'b1 : addr_q - 1'b1;  // [R1]
  assign wr_en     = byte_done && !rw_q;
  assign rd_load   = (instr_done && shift_d[15]) || (byte_done && rw_q);
  assign rd_addr   = instr_done ? shift_d[`SCR_ADDR_W-1:0] : addr_step;

  always_comb begin
    case (rd_addr)
      `SCR_OFS_IFCFG:      rd_data = {rst_req_q, order_q, step_q, sdo_en_q,
                                      sdo_en_q, step_q, order_q, rst_req_q};  // [R5]
      `SCR_OFS_TYPE:       rd_data = TYPE_CODE;  // [R4]
      `SCR_OFS_ID_LOW:     rd_data = ID_LOW;
      `SCR_OFS_ID_HIGH:    rd_data = ID_HIGH;
      `SCR_OFS_TEST_CTRL:  rd_data = test_ctrl_q;
      `SCR_OFS_CONST_I_LO: rd_data = ci_lo_q;
      `SCR_OFS_CONST_I_HI: rd_data = ci_hi_q;
      `SCR_OFS_CONST_Q_LO: rd_data = cq_lo_q;
      `SCR_OFS_CONST_Q_HI: rd_data = cq_hi_q;
      default:             rd_data = `SCR_UNMAPPED_READ;
    endcase
  end

  // frame engine; deselect abandons any partial byte
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || !sel) begin
      state_q   <= scr_pkg::ST_INSTR;
      bit_cnt_q <= 4'h0;
      shift_q   <= 16'h0000;
      rw_q      <= 1'b0;
      addr_q    <= `SCR_OFS_IFCFG;
    end else if (pin.rise[`SCR_PIN_SCLK]) begin
      shift_q   <= shift_d;
      bit_cnt_q <= bit_cnt_q + 4'h1;
      case (state_q)
        scr_pkg::ST_INSTR: begin
          if (instr_done) begin
            state_q   <= scr_pkg::ST_DATA;
            bit_cnt_q <= 4'h0;
            rw_q      <= shift_d[15];
            addr_q    <= shift_d[`SCR_ADDR_W-1:0];
          end
        end
        scr_pkg::ST_DATA: begin
          if (byte_done) begin
            bit_cnt_q <= 4'h0;
            addr_q    <= addr_step;  // [R1]
          end
        end
        default: begin
          state_q <= scr_pkg::ST_INSTR;
        end
      endcase
    end
  end

  // read data: loaded on the last rising edge, shifted out on falling edges
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      tx_q       <= 8'h00;
      sdio_out_q <= 1'b0;
      sdo_q      <= 1'b0;
    end else if (rd_load) begin
      tx_q <= rd_data;
    end else if (sel && pin.fall[`SCR_PIN_SCLK] && (state_q == scr_pkg::ST_DATA) && rw_q) begin
      sdio_out_q <= order_q ? tx_q[0] : tx_q[7];  // [R2]
      sdo_q      <= order_q ? tx_q[0] : tx_q[7];  // [R2]
      tx_q       <= order_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
    end
  end

  // drive only from the first falling edge of a read, so the host has let go
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || !sel || !rw_q || (state_q != scr_pkg::ST_DATA)) begin
      sdio_oe_q <= 1'b0;
      sdo_oe_q  <= 1'b0;
    end else if (pin.fall[`SCR_PIN_SCLK]) begin
      sdio_oe_q <= !sdo_en_q;
      sdo_oe_q  <= sdo_en_q;
    end
  end

  // soft reset request: a new request wins over the self-clear
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      rst_req_q <= 1'b0;
      rst_cnt_q <= 5'h00;
    end else if (wr_en && (addr_q == `SCR_OFS_IFCFG) && wr_byte[`SCR_IFCFG_RST_BIT]) begin
      rst_req_q <= 1'b1;  // [R3]
      rst_cnt_q <= 5'h00;
    end else if (rst_req_q) begin
      rst_cnt_q <= rst_cnt_q + 5'h01;
      if (rst_cnt_q == 5'(`SCR_SOFT_RESET_CYC - 1)) begin
        rst_req_q <= 1'b0;  // [R3]
      end
    end
  end

  // interface controls; a write in the same byte as a reset request is lost
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || rst_req_q) begin
      {sdo_en_q, step_q, order_q} <= `SCR_IFCFG_RESET;  // [R3]
    end else if (wr_en && (addr_q == `SCR_OFS_IFCFG)) begin
      sdo_en_q <= wr_byte[`SCR_IFCFG_SDOEN_BIT];
      step_q   <= wr_byte[`SCR_IFCFG_STEP_BIT];   // [R1]
      order_q  <= wr_byte[`SCR_IFCFG_ORDER_BIT];  // [R2]
    end
  end

  // test registers; type and id offsets have no storage, so writes vanish
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || rst_req_q) begin
      test_ctrl_q <= `SCR_TEST_CTRL_RESET;  // [R3]
      ci_lo_q     <= `SCR_CONST_RESET;
      ci_hi_q     <= `SCR_CONST_RESET;
      cq_lo_q     <= `SCR_CONST_RESET;
      cq_hi_q     <= `SCR_CONST_RESET;
    end else if (wr_en) begin
      case (addr_q)
        `SCR_OFS_TEST_CTRL:  test_ctrl_q <= wr_byte;
        `SCR_OFS_CONST_I_LO: ci_lo_q     <= wr_byte;
        `SCR_OFS_CONST_I_HI: ci_hi_q     <= wr_byte;
        `SCR_OFS_CONST_Q_LO: cq_lo_q     <= wr_byte;
        `SCR_OFS_CONST_Q_HI: cq_hi_q     <= wr_byte;
        default: begin
          test_ctrl_q <= test_ctrl_q;  // [R4]
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_SOFT_RESET_ACTIVE <= 1'b0;
      O_CONST_TEST_ENABLE <= 1'b0;
      O_CONST_I_SAMPLE    <= 16'h0000;
      O_CONST_Q_SAMPLE    <= 16'h0000;
    end else begin
      O_SOFT_RESET_ACTIVE <= rst_req_q;
      O_CONST_TEST_ENABLE <= test_ctrl_q[`SCR_TEST_EN_BIT];
      O_CONST_I_SAMPLE    <= {ci_hi_q, ci_lo_q};
      O_CONST_Q_SAMPLE    <= {cq_hi_q, cq_lo_q};
    end
  end

  assign O_SDIO_OUT = sdio_out_q;
  assign O_SDIO_OE  = sdio_oe_q;
  assign O_SDO      = sdo_q;
  assign O_SDO_OE   = sdo_oe_q;

endmodule : scr_top

// ### testbench/scr_host_model.sv
/*
  Serial host model: frames on chip select, serial clock and data wire.
  Assumes the bench sets lsb and w4 to follow the configuration byte.
*/
module scr_host_model (
  input  wire logic i_clk,
  input  wire logic i_sdio_out,
  input  wire logic i_sdio_oe,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lsb   = 1'b0;
  logic w4    = 1'b0;
  logic drv   = 1'b0;
  logic bit_q = 1'b0;
  logic flip  = 1'b0;

  // an undriven line toggles so a stale level never passes as data
  always @(negedge i_clk) begin
    flip <= ~flip;
  end
  assign o_sdio = i_sdio_oe ? i_sdio_out : (drv ? bit_q : flip);

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
  end

  task automatic one(input logic v, output logic r);
    bit_q = v;
    repeat (5) @(negedge i_clk);
    r = w4 ? (i_sdo_oe ? i_sdo : flip) : o_sdio;
    o_sclk = 1'b1;
    repeat (5) @(negedge i_clk);
    o_sclk = 1'b0;
  endtask : one

  task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                      input logic [31:0] wd, output logic [31:0] rdv);
    logic [15:0] ins;
    logic [7:0]  b;
    logic        r;
    ins = {rd, a};
    rdv = '0;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    drv = 1'b1;
    repeat (4) @(negedge i_clk);
    for (int i = 0; i < 16; i++) begin
      one(ins[lsb ? i : 15 - i], r);
    end
    drv = !rd;
    for (int k = 0; k < n; k++) begin
      b = wd[8*k +: 8];
      for (int i = 0; i < 8; i++) begin
        one(b[lsb ? i : 7 - i], r);
        rdv[8*k + (lsb ? i : 7 - i)] = r;
      end
    end
    repeat (5) @(negedge i_clk);
    o_cs_n = 1'b1;
    drv = 1'b0;
    repeat (12) @(negedge i_clk);
  endtask : xfer
endmodule : scr_host_model

// ### testbench/scr_properties.sv
/*
  Checker on the ports of the register bank top.
  Assumes one clock domain and a synchronous active-high reset.
*/
module scr_properties (
  input wire logic        I_CLOCK,
  input wire logic        I_RESET,
  input wire logic        I_CS_N,
  input wire logic        O_SDIO_OE,
  input wire logic        O_SDO_OE,
  input wire logic        O_SOFT_RESET_ACTIVE,
  input wire logic        O_CONST_TEST_ENABLE,
  input wire logic [15:0] O_CONST_I_SAMPLE,
  input wire logic [15:0] O_CONST_Q_SAMPLE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);

  // eight cycles covers the pin sync latency after deselect
  idle_quiet_a: assert property (I_CS_N [*8] |-> !O_SDIO_OE && !O_SDO_OE)
    else $error("output enabled while deselected");
  oe_single_a: assert property (!(O_SDIO_OE && O_SDO_OE))
    else $error("both data outputs enabled");
  softrst_hold_a: assert property ($rose(O_SOFT_RESET_ACTIVE) |-> O_SOFT_RESET_ACTIVE [*8])
    else $error("soft reset ended too early");
  softrst_clear_a: assert property ($rose(O_SOFT_RESET_ACTIVE) |-> ##[14:18] !O_SOFT_RESET_ACTIVE)
    else $error("soft reset bit did not clear");
  softrst_dflt_a: assert property (O_SOFT_RESET_ACTIVE |-> ##[0:2]
    (!O_CONST_TEST_ENABLE && O_CONST_I_SAMPLE == 16'h0000 && O_CONST_Q_SAMPLE == 16'h0000))
    else $error("test registers not at defaults in soft reset");

  cover property ($rose(O_SDIO_OE));
  cover property ($rose(O_SDO_OE));
  cover property ($rose(O_SOFT_RESET_ACTIVE));
endmodule : scr_properties

bind scr_top scr_properties u_props (
  .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_CS_N(I_CS_N), .O_SDIO_OE(O_SDIO_OE),
  .O_SDO_OE(O_SDO_OE), .O_SOFT_RESET_ACTIVE(O_SOFT_RESET_ACTIVE),
  .O_CONST_TEST_ENABLE(O_CONST_TEST_ENABLE), .O_CONST_I_SAMPLE(O_CONST_I_SAMPLE),
  .O_CONST_Q_SAMPLE(O_CONST_Q_SAMPLE));

// ### testbench/tb.sv
/*
  Top bench: clock, reset, host model and register sequences.
  Assumes the design's default type and id parameters.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n, sclk, sdio, sdio_o, sdio_oe, sdo, sdo_oe, sra, tst;
  logic [15:0] ci, cq;
  logic [31:0] rv;
  int          miscompares = 0;
  int          n_compared = 0;

  initial begin
    forever #2.5 clk = ~clk;
  end

  scr_top u_dut (.I_CLOCK(clk), .I_RESET(rst), .I_CS_N(cs_n), .I_SCLK(sclk), .I_SDIO_IN(sdio),
    .O_SDIO_OUT(sdio_o), .O_SDIO_OE(sdio_oe), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
    .O_SOFT_RESET_ACTIVE(sra), .O_CONST_TEST_ENABLE(tst), .O_CONST_I_SAMPLE(ci),
    .O_CONST_Q_SAMPLE(cq));
  scr_host_model u_host (.i_clk(clk), .i_sdio_out(sdio_o), .i_sdio_oe(sdio_oe), .i_sdo(sdo),
    .i_sdo_oe(sdo_oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdio(sdio));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    u_host.xfer(1'b0, a, n, d, rv);
  endtask : wr

  task automatic rd(input logic [14:0] a, input int n, input logic [31:0] e);
    u_host.xfer(1'b1, a, n, 32'h0, rv);
    chk(rv, e);
  endtask : rd

  initial begin
    // pin synchronisers clear on the same reset edges as the core
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(15'h0003, 3, 32'h0000005a);
    wr(15'h0003, 1, 32'hff);
    rd(15'h0003, 1, 32'h5a);
    wr(15'h0000, 1, 32'h04);
    rd(15'h0000, 1, 32'h24);
    rd(15'h0003, 3, 32'ha73c5a);
    wr(15'h0521, 2, 32'hcdab);
    chk(ci, 32'hcdab);
    wr(15'h0000, 1, 32'h0c);
    u_host.w4 = 1'b1;
    rd(15'h0521, 2, 32'hcdab);
    rd(15'h0000, 1, 32'h3c);
    wr(15'h0000, 1, 32'h0e);
    u_host.lsb = 1'b1;
    rd(15'h0000, 1, 32'h7e);
    wr(15'h0524, 1, 32'h5a);
    chk(cq, 32'h5a00);
    wr(15'h0520, 1, 32'h1e);
    chk(tst, 32'h1);
    wr(15'h0000, 1, 32'h0f);
    // controls written as ones, so only the soft reset can clear them
    repeat (30) @(negedge clk);
    u_host.lsb = 1'b0;
    u_host.w4 = 1'b0;
    chk({cq, ci}, 32'h0);
    chk(tst, 32'h0);
    rd(15'h0000, 1, 32'h00);
    rd(15'h0520, 1, 32'h1c);
    tally_and_finish();
  end

  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
